// file: rtl/can_trig_pkg.sv
/*
 * Shared constants, enumerations and carrier structs for the passive CAN trigger monitor.
 * Assumes a 10 MHz sampling clock and a digitized bus line brought in from outside its domain.
 */
package can_trig_pkg;

	localparam int CLK_HZ = 10000000;
	localparam int MAX_BIT_HZ = 1000000;
	localparam logic [15:0] MIN_BIT_CYC = 16'(CLK_HZ / MAX_BIT_HZ);
	localparam logic [6:0] PCT_FULL = 7'h64;
	localparam int BASE_ID_W = 11;
	localparam int EXT_ID_W = 18;
	localparam int ID_W = 29;
	localparam int CRC_W = 15;
	localparam logic [14:0] CRC_POLY = 15'h4599;
	localparam logic [2:0] STUFF_RUN = 3'h5;
	localparam logic [2:0] EOF_BITS = 3'h7;
	localparam logic [3:0] MAX_BYTES = 4'h8;
	localparam logic [2:0] IDLE_BITS = 3'h7;

	typedef enum logic [2:0] {TRG_SOF, TRG_EOF, TRG_FRAME, TRG_ERROR, TRG_ID, TRG_ID_DATA} trig_mode_e;
	typedef enum logic [2:0] {FS_DATA, FS_REMOTE, FS_DATA_REMOTE, FS_ERROR, FS_OVERLOAD} frame_sel_e;
	typedef enum logic [1:0] {IDT_BASE, IDT_EXT, IDT_ANY} id_type_e;
	typedef enum logic [1:0] {CMP_EQ, CMP_RANGE} id_cmp_e;

	typedef struct packed {
		logic stuffErr;
		logic formErr;
		logic ackErr;
		logic crcErr;
	} err_set_s;

	typedef struct packed {
		trig_mode_e mode;
		frame_sel_e frameSel;
		id_type_e idType;
		id_cmp_e idCmp;
		logic lowLine;
		logic [15:0] bitCycles;
		logic [6:0] samplePct;
		err_set_s errEnable;
		logic [28:0] idValue;
		logic [28:0] idMask;
		logic [28:0] idHigh;
		logic [63:0] dataValue;
		logic [63:0] dataMask;
		logic [3:0] dataLen;
	} trig_cfg_s;

	typedef struct packed {
		logic trigger;
		logic frameDone;
		logic extended;
		logic remote;
		logic [28:0] ident;
		logic [3:0] dlc;
		err_set_s errors;
	} trig_stat_s;

endpackage

// file: rtl/can_frame_trigger_monitor.sv
/*
 * Passive CAN frame trigger monitor: bit timing, destuffing, frame parsing and trigger selection.
 * Assumes a digitized bus line from outside the clock domain and a configuration held stable by the user.
 */
// Notes on behaviour
// [RULE1] Start-of-frame mode fires on the falling edge that starts the dominant SOF bit.
// [RULE2] End-of-frame mode fires after the seventh recessive end-of-frame bit.
// [RULE3] Whole 11-bit base or 29-bit extended identifier is extracted.
// [RULE4] Extended identifier is 11-bit first part followed by 18-bit extension.
// [RULE5] Lower identifier wins arbitration; nodes handle this, monitor only observes.
// [RULE6] A node losing arbitration stops, waits, then retries its frame.
// [RULE7] One dominant SOF bit begins every frame and starts parsing.
// [RULE8] Substitute remote request bit expected only in extended frames at RTR position.
// [RULE9] Data length code gives data bytes, clamped to at most eight.
// [RULE10] Ack slot sent recessive; a correct receiver drives it dominant.
// [RULE11] Frames classified as data, remote, error or overload.
// [RULE12] Data frame selection fires only when identifier format matches the type setting.
// [RULE13] Remote frame has data layout without data field; type filter applies.
// [RULE14] Data-or-remote selection fires on both, still filtered by identifier type.
// [RULE15] Error frame selection fires on an error flag inside the stuffed fields; a flag reaching the end field counts as overload.
// [RULE16] Overload frame selection fires on an overload frame between frames; here it fires only on a dominant bit inside the end field.
// [RULE17] Error mode fires on any enabled stuff, form, ack or CRC error.
// [RULE18] Identifier mode fires on masked equality or on an identifier range.
// [RULE19] Identifier and data mode fires at the end of the last pattern byte.
// [RULE20] Bit value taken at a programmable percentage sample point.
// [RULE21] Bit timing resynchronizes on recessive-to-dominant edges inside the frame.
// [RULE22] Bit rate is a configurable cycle count, limited to 1 Mbit/s.
// [RULE23] Stuff bits after five equal bits are removed through the CRC sequence.
// [RULE24] A sixth equal bit in stuffed fields flags a stuff error.
// [RULE25] Identifier type selects base, extended or any format.
// [RULE26] Bit period and sample instant come from a counter and configured divisor.
// [RULE27] Low bus line is inverted so dominant decodes the same as the high line.
`timescale 1ns/1ns
module can_frame_trigger_monitor
	import can_trig_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic busLine,
	input wire trig_cfg_s cfg,
	output trig_stat_s status
);

	typedef enum {ST_IDLE, ST_SOF, ST_ID_A, ST_RTR_SRR, ST_IDE, ST_ID_B, ST_RTR_EXT, ST_RSV_EXT, ST_RSV, ST_DLC,
		ST_DATA, ST_CRC, ST_CRC_DEL, ST_ACK, ST_ACK_DEL, ST_EOF, ST_ERRFLAG, ST_ERRDEL} parse_state_e;

	// Two flops before any logic reads the pin.
	logic sync1_q, sync2_q, prevLvl_q;

	// Level in high-line sense: 0 means dominant.
	wire logic lvl = cfg.lowLine ? ~sync2_q : sync2_q; // [RULE27]
	wire logic fallEdge = prevLvl_q & ~lvl;

	// The edge detector resets to the recessive idle level, so no false start edge follows reset.
	always_ff @(posedge ref_clk) begin
		sync1_q <= busLine;
		sync2_q <= sync1_q;
		prevLvl_q <= rst ? 1'b1 : lvl;
	end

	// Bit timing.
	wire logic [15:0] bitCyc = (cfg.bitCycles < MIN_BIT_CYC) ? MIN_BIT_CYC : cfg.bitCycles; // [RULE22]
	wire logic [22:0] spProd = bitCyc * cfg.samplePct;
	wire logic [15:0] spCyc = 16'(spProd / 23'(PCT_FULL)); // [RULE20] [RULE26]
	logic [15:0] bitCnt_q;
	wire logic inFrame;
	wire logic resync = fallEdge & inFrame; // [RULE21]
	wire logic sofEdge = fallEdge & ~inFrame;
	// Bits are only sampled inside a frame; the idle line is watched for a start edge alone.
	wire logic sampleNow = (bitCnt_q == spCyc) & inFrame;
	always_ff @(posedge ref_clk) begin
		if (rst | resync | sofEdge)
			bitCnt_q <= 16'h1; // [RULE21] [RULE26]
		else if (bitCnt_q >= bitCyc - 16'h1)
			bitCnt_q <= 16'h0;
		else
			bitCnt_q <= bitCnt_q + 16'h1;
	end

	parse_state_e st_q, st_d;
	assign inFrame = (st_q != ST_IDLE);

	// Destuffing state.
	logic [2:0] runLen_q;
	logic runLvl_q;
	// A stuff bit can follow the final CRC bit and then lands in the delimiter slot.
	// Only that one slot is covered, so a run ending in the delimiter itself is not mistaken for stuffing.
	wire logic stuffTail = (st_q == ST_CRC_DEL) & (runLen_q == STUFF_RUN);
	wire logic stuffZone = (st_q inside {ST_ID_A, ST_RTR_SRR, ST_IDE, ST_ID_B, ST_RTR_EXT, ST_RSV_EXT, ST_RSV,
		ST_DLC, ST_DATA, ST_CRC}) | stuffTail;
	wire logic isStuffBit = stuffZone & (runLen_q == STUFF_RUN) & (lvl != runLvl_q); // [RULE23]
	wire logic stuffErrNow = stuffZone & (runLen_q == STUFF_RUN) & (lvl == runLvl_q); // [RULE24]
	wire logic bitValid = sampleNow & inFrame & ~isStuffBit;

	logic [6:0] fieldCnt_q;
	logic [28:0] id_q;
	logic ext_q, rtr_q;
	logic [3:0] dlc_q;
	logic [63:0] data_q;
	logic [14:0] crc_q, crcRx_q;
	logic [2:0] recCnt_q;

	function automatic logic [3:0] clampLen(input logic [3:0] code);
		clampLen = (code > MAX_BYTES) ? MAX_BYTES : code; // [RULE9]
	endfunction

	// The last length bit is still on the line when the data field length is chosen.
	// Reading the stored code alone would lag that choice by one bit.
	wire logic [3:0] dlcNow = {dlc_q[2:0], lvl};
	wire logic [3:0] nBytes = rtr_q ? 4'h0 : clampLen(dlc_q);
	wire logic [6:0] dataBits = {nBytes, 3'h0};
	wire logic [3:0] patLen = clampLen(cfg.dataLen);
	wire logic crcFb = lvl ^ crc_q[CRC_W-1];
	wire logic [14:0] crcNext = {crc_q[13:0], 1'b0} ^ (crcFb ? CRC_POLY : 15'h0);
	wire logic lastInField = bitValid & (fieldCnt_q == 7'h0);

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ST_IDLE: begin
				if (sofEdge)
					st_d = ST_SOF; // [RULE7]
			end
			// The start bit has its own state so that its sample is not shifted into the identifier.
			ST_SOF: begin
				if (bitValid)
					st_d = ST_ID_A; // [RULE7]
			end
			ST_ID_A: begin
				if (lastInField)
					st_d = ST_RTR_SRR;
			end
			ST_RTR_SRR: begin
				if (bitValid)
					st_d = ST_IDE;
			end
			ST_IDE: begin
				if (bitValid)
					st_d = lvl ? ST_ID_B : ST_RSV;
			end
			ST_ID_B: begin
				if (lastInField)
					st_d = ST_RTR_EXT;
			end
			ST_RTR_EXT: begin
				if (bitValid)
					st_d = ST_RSV_EXT;
			end
			// Extended frames carry two reserved bits, base frames only one.
			ST_RSV_EXT: begin
				if (bitValid)
					st_d = ST_RSV;
			end
			ST_RSV: begin
				if (bitValid)
					st_d = ST_DLC;
			end
			ST_DLC: begin
				if (lastInField)
					st_d = (rtr_q || dlcNow == 4'h0) ? ST_CRC : ST_DATA;
			end
			ST_DATA: begin
				if (lastInField)
					st_d = ST_CRC;
			end
			ST_CRC: begin
				if (lastInField)
					st_d = ST_CRC_DEL;
			end
			// A trailing stuff bit must not be taken for the delimiter, so only a valid bit ends it.
			ST_CRC_DEL: begin
				if (bitValid)
					st_d = ST_ACK;
			end
			ST_ACK: begin
				if (sampleNow)
					st_d = ST_ACK_DEL;
			end
			ST_ACK_DEL: begin
				if (sampleNow)
					st_d = ST_EOF;
			end
			// A dominant bit inside the end field is read as an overload flag.
			ST_EOF: begin
				if (sampleNow && (!lvl || fieldCnt_q == 7'h0))
					st_d = lvl ? ST_IDLE : ST_ERRFLAG;
			end
			ST_ERRFLAG: begin
				if (sampleNow && lvl)
					st_d = ST_ERRDEL;
			end
			ST_ERRDEL: begin
				if (sampleNow && recCnt_q == IDLE_BITS - 3'h1)
					st_d = ST_IDLE;
			end
		endcase
		// A stuff error overrides any field step and parks the parser until the line goes quiet.
		if (stuffErrNow && sampleNow)
			st_d = ST_ERRFLAG;
	end

	// Field lengths loaded on entry to each counted field.
	logic [6:0] nextCnt;
	always_comb begin
		nextCnt = 7'h0;
		unique case (st_d)
			ST_ID_A: nextCnt = 7'(BASE_ID_W - 1);
			ST_ID_B: nextCnt = 7'(EXT_ID_W - 1);
			ST_DLC: nextCnt = 7'h3;
			ST_DATA: nextCnt = {clampLen(dlcNow), 3'h0} - 7'h1;
			ST_CRC: nextCnt = 7'(CRC_W - 1);
			ST_EOF: nextCnt = 7'(EOF_BITS - 3'h1);
			default: nextCnt = 7'h0;
		endcase
	end

	// Events of this cycle.
	// A dominant stuff bit in the delimiter slot is legal, hence the valid-bit qualifier.
	wire logic formErrNow = bitValid & ~lvl & (st_q inside {ST_CRC_DEL, ST_ACK_DEL}); // [RULE11]
	wire logic ackErrNow = sampleNow & lvl & (st_q == ST_ACK); // [RULE10]
	wire logic crcErrNow = (st_q == ST_CRC) & lastInField & ({crcRx_q[13:0], lvl} != crc_q);
	wire logic eofDone = (st_q == ST_EOF) & sampleNow & lvl & (fieldCnt_q == 7'h0); // [RULE2]
	wire logic errFrame = (st_d == ST_ERRFLAG) & (st_q != ST_ERRFLAG) & (st_q != ST_EOF);
	wire logic ovlFrame = (st_d == ST_ERRFLAG) & (st_q == ST_EOF); // [RULE16]
	wire err_set_s errNow = '{stuffErr: stuffErrNow & sampleNow, formErr: formErrNow, ackErr: ackErrNow,
		crcErr: crcErrNow};

	wire logic typeOk = (cfg.idType == IDT_ANY) | ((cfg.idType == IDT_EXT) == ext_q); // [RULE25]
	wire logic frameSelOk = (cfg.frameSel == FS_DATA_REMOTE) |
		((cfg.frameSel == FS_REMOTE) == rtr_q); // [RULE12] [RULE13] [RULE14]
	wire logic [28:0] idNorm = ext_q ? id_q : {18'h0, id_q[10:0]}; // [RULE3]
	wire logic idEq = ((idNorm ^ cfg.idValue) & cfg.idMask) == 29'h0;
	wire logic idInRange = (idNorm >= cfg.idValue) & (idNorm <= cfg.idHigh);
	wire logic idOk = typeOk & ((cfg.idCmp == CMP_EQ) ? idEq : idInRange); // [RULE18]
	wire logic [6:0] dataGot = dataBits - fieldCnt_q;
	wire logic patEnd = (st_q == ST_DATA) & bitValid & (dataGot == {patLen, 3'h0});
	wire logic [63:0] patShift = {data_q[62:0], lvl} << (7'(64) - {patLen, 3'h0});
	wire logic [63:0] patMaskSh = cfg.dataMask << (7'(64) - {patLen, 3'h0});
	wire logic [63:0] valSh = cfg.dataValue << (7'(64) - {patLen, 3'h0});
	wire logic dataOk = ((patShift ^ valSh) & patMaskSh) == 64'h0;
	wire logic ctrlEnd = (st_q == ST_DLC) & lastInField;

	logic fire;
	always_comb begin
		fire = 1'b0;
		unique case (cfg.mode)
			TRG_SOF: fire = sofEdge; // [RULE1]
			TRG_EOF: fire = eofDone; // [RULE2]
			TRG_FRAME: begin
				if (cfg.frameSel == FS_ERROR)
					fire = errFrame; // [RULE15]
				else if (cfg.frameSel == FS_OVERLOAD)
					fire = ovlFrame; // [RULE16]
				else
					fire = ctrlEnd & typeOk & frameSelOk; // [RULE12] [RULE13] [RULE14]
			end
			TRG_ERROR: fire = |(errNow & cfg.errEnable); // [RULE17]
			TRG_ID: fire = ctrlEnd & idOk; // [RULE18]
			TRG_ID_DATA: fire = patEnd & ~rtr_q & idOk & dataOk & (patLen <= nBytes); // [RULE19]
			default: fire = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_q <= ST_IDLE;
			fieldCnt_q <= 7'h0;
			runLen_q <= 3'h0;
			runLvl_q <= 1'b1;
			recCnt_q <= 3'h0;
		end else begin
			st_q <= st_d;
			if (st_d != st_q)
				fieldCnt_q <= nextCnt;
			else if (bitValid || (sampleNow && st_q == ST_EOF))
				fieldCnt_q <= fieldCnt_q - 7'h1;
			if (sofEdge) begin
				runLen_q <= 3'h1;
				runLvl_q <= 1'b0;
			end else if (sampleNow && stuffZone) begin
				runLen_q <= (lvl == runLvl_q && !isStuffBit) ? runLen_q + 3'h1 : 3'h1; // [RULE23]
				runLvl_q <= lvl;
			end
			if (st_q != ST_ERRDEL)
				recCnt_q <= 3'h0;
			else if (sampleNow)
				recCnt_q <= lvl ? recCnt_q + 3'h1 : 3'h0;
		end
	end

	// Frame content capture.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			id_q <= 29'h0;
			ext_q <= 1'b0;
			rtr_q <= 1'b0;
			dlc_q <= 4'h0;
			data_q <= 64'h0;
			crc_q <= 15'h0;
			crcRx_q <= 15'h0;
		end else if (sofEdge) begin
			id_q <= 29'h0;
			ext_q <= 1'b0;
			rtr_q <= 1'b0;
			crc_q <= 15'h0;
		end else if (bitValid) begin
			if (st_q inside {ST_ID_A, ST_ID_B})
				id_q <= {id_q[27:0], lvl}; // [RULE3] [RULE4]
			if (st_q == ST_RTR_SRR)
				rtr_q <= lvl; // [RULE8]
			if (st_q == ST_IDE)
				ext_q <= lvl;
			if (st_q == ST_RTR_EXT)
				rtr_q <= lvl; // [RULE8] [RULE13]
			if (st_q == ST_DLC)
				dlc_q <= {dlc_q[2:0], lvl}; // [RULE9]
			if (st_q == ST_DATA)
				data_q <= {data_q[62:0], lvl};
			if (st_q == ST_CRC)
				crcRx_q <= {crcRx_q[13:0], lvl};
			else
				crc_q <= crcNext;
		end
	end

	// All outputs come from flops.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			status <= '0;
		end else begin
			status.trigger <= fire;
			status.frameDone <= eofDone;
			status.errors <= errNow;
			status.extended <= ext_q;
			status.remote <= rtr_q;
			status.ident <= idNorm;
			status.dlc <= dlc_q;
		end
	end

endmodule

// file: tb/can_trig_props.sv
/*
 * Port-level assertions for the CAN trigger monitor.
 * Assumes cfg stays static while a frame is on the line.
 */
`timescale 1ns/1ns
module can_trig_props
	import can_trig_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic busLine,
	input wire trig_cfg_s cfg,
	input wire trig_stat_s status
);
	logic [31:0] highCnt;
	wire [31:0] bitLen = 32'(cfg.bitCycles);
	always_ff @(posedge ref_clk) begin
		highCnt <= (rst || !busLine) ? 32'h0 : highCnt + 32'h1;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	chk_sof_fire: assert property (cfg.mode == TRG_SOF && $fell(busLine) && $past(highCnt) > bitLen * 11
		|-> ##[2:5] status.trigger) else $error("no trigger after start bit");
	chk_sof_cause: assert property (status.trigger && cfg.mode == TRG_SOF
		|-> !$past(busLine, 2) && !$past(busLine, 3)) else $error("start trigger without dominant line");
	chk_eof_done: assert property (status.frameDone |-> highCnt >= bitLen * 6) else $error("frame end too early");
	chk_eof_trig: assert property (status.trigger && cfg.mode == TRG_EOF |-> highCnt >= bitLen * 6)
		else $error("end trigger too early");
	chk_err_gate: assert property (status.trigger && cfg.mode == TRG_ERROR
		|-> |((status.errors | $past(status.errors) | $past(status.errors, 2) | $past(status.errors, 3)) & cfg.errEnable))
		else $error("error trigger without enabled error");
	chk_base_filter: assert property (status.trigger && cfg.mode == TRG_FRAME && cfg.idType == IDT_BASE
		|-> !status.extended) else $error("extended frame passed base filter");
	chk_ext_filter: assert property (status.trigger && cfg.mode == TRG_FRAME && cfg.idType == IDT_EXT
		|-> status.extended) else $error("base frame passed extended filter");
	chk_remote_sel: assert property (status.trigger && cfg.mode == TRG_FRAME && cfg.frameSel == FS_REMOTE
		|-> status.remote) else $error("remote selection fired on data frame");
	chk_id_range: assert property (status.trigger && cfg.mode == TRG_ID && cfg.idCmp == CMP_RANGE
		|-> status.ident >= cfg.idValue && status.ident <= cfg.idHigh) else $error("identifier outside range");
	chk_id_equal: assert property (status.trigger && cfg.mode == TRG_ID && cfg.idCmp == CMP_EQ
		|-> ((status.ident ^ cfg.idValue) & cfg.idMask) == 29'h0) else $error("identifier mismatch");
	chk_stuff_pulse: assert property (status.errors.stuffErr |=> !status.errors.stuffErr)
		else $error("stuff error not a pulse");
endmodule

// file: tb/can_node_model.sv
/*
 * Behavioural CAN node sending one frame at a time on the digitized line.
 * Assumes the monitor samples on the rising edge; the node changes the line on the falling edge.
 */
`timescale 1ns/1ns
module can_node_model
	import can_trig_pkg::*;
#(
	parameter int BIT_CYC = 20
)
(
	input wire logic ref_clk,
	output logic busLine = 1'h1
);
	logic [159:0] bits;
	int n;
	task automatic put(input logic b);
		bits[n] = b;
		n++;
	endtask
	task automatic drive(input logic b);
		busLine = b;
		repeat (BIT_CYC) @(negedge ref_clk);
	endtask
	// A non-zero abort cuts the frame short with an error flag, so stuffing is not kept there.
	task automatic send(input logic ext, input logic [28:0] id, input logic rtr, input logic [3:0] dlc,
		input logic [63:0] data, input logic ack, input int abort);
		logic [14:0] crc;
		logic last;
		int run;
		int i;
		n = 0;
		crc = 15'h0;
		id = ext ? id : {id[10:0], 18'h0};
		put(1'h0);
		for (i = 28; i >= 0; i--) begin
			if (i == 17 && ext) begin
				put(1'h1);
				put(1'h1);
			end
			if (i >= 18 || ext) put(id[i]);
		end
		put(rtr);
		put(1'h0);
		put(1'h0);
		for (i = 3; i >= 0; i--) put(dlc[i]);
		for (i = 0; i < (rtr ? 0 : dlc * 8); i++) put(data[63 - i]);
		for (i = 0; i < n; i++) begin
			last = bits[i] ^ crc[14];
			crc = {crc[13:0], 1'h0} ^ (last ? CRC_POLY : 15'h0);
		end
		for (i = 14; i >= 0; i--) put(crc[i]);
		run = 0;
		last = 1'h1;
		for (i = 0; i < n && !(abort != 0 && i == abort); i++) begin
			drive(bits[i]);
			run = (bits[i] == last) ? run + 1 : 1;
			last = bits[i];
			if (run == 5) begin
				drive(~last);
				last = ~last;
				run = 1;
			end
		end
		if (abort != 0) begin
			repeat (6) drive(1'h0);
			repeat (8) drive(1'h1);
		end else begin
			drive(1'h1);
			drive(!ack);
			repeat (8) drive(1'h1);
		end
		repeat (14) drive(1'h1);
	endtask
endmodule

// file: tb/can_frame_trigger_monitor_tb.sv
/*
 * Self-checking bench: frames from the node model against each trigger mode.
 * Assumes one trigger per fired frame and none for filtered frames.
 */
`timescale 1ns/1ns
module can_frame_trigger_monitor_tb
	import can_trig_pkg::*;
;
	logic ref_clk = 1'h0;
	logic rst = 1'h1;
	wire logic busLine;
	trig_cfg_s cfg = '0;
	trig_stat_s status;
	logic [28:0] expQ[$];
	logic [28:0] expId;
	logic [28:0] lastId = 29'h0;
	int num_errors = 0;
	int n_compared = 0;
	int seedVal;
	can_node_model #(.BIT_CYC(20)) node_u (.ref_clk(ref_clk), .busLine(busLine));
	can_frame_trigger_monitor dut_u (.ref_clk(ref_clk), .rst(rst), .busLine(busLine), .cfg(cfg), .status(status));
	initial begin
		forever #50 ref_clk = ~ref_clk;
	end
	task automatic end_of_test();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic miss(input logic [28:0] e, input logic [28:0] g);
		num_errors++;
		$display("ERROR %0t exp %h got %h", $time, e, g);
	endtask
	always @(posedge ref_clk) begin
		if (status.trigger === 1'h1) begin
			n_compared++;
			if (expQ.size() == 0) begin
				miss(29'h0, status.ident);
			end else begin
				expId = expQ.pop_front();
				if (expId !== status.ident) miss(expId, status.ident);
			end
		end
	end
	task automatic run(input trig_mode_e m, input frame_sel_e fs, input id_type_e it, input logic ext,
		input logic rtr, input logic ack, input int abort, input logic fire);
		logic [28:0] id;
		logic [63:0] data;
		id = ext ? 29'($urandom) : 29'($urandom & 32'h7FF);
		data = {$urandom, $urandom};
		cfg.mode = m;
		cfg.frameSel = fs;
		cfg.idType = it;
		cfg.idValue = fire ? id : id ^ 29'h1;
		cfg.idHigh = cfg.idValue + 29'h10;
		cfg.dataValue = {48'h0, data[63:48]};
		if (fire) expQ.push_back(m == TRG_SOF ? lastId : id);
		node_u.send(ext, id, rtr, 4'($urandom_range(2, 8)), data, ack, abort);
		lastId = id;
		n_compared++;
		if (expQ.size() != 0) begin
			miss(29'h0, 29'(expQ.size()));
			expQ.delete();
		end
	endtask
	initial begin
		seedVal = $urandom(27484);
		cfg.bitCycles = 16'h0014;
		cfg.samplePct = 7'h4B;
		cfg.idMask = '1;
		cfg.dataMask = 64'hFFFF;
		cfg.dataLen = 4'h2;
		repeat (20) @(negedge ref_clk);
		rst = 1'h0;
		repeat (300) @(negedge ref_clk);
		run(TRG_SOF, FS_DATA, IDT_ANY, 1'h0, 1'h0, 1'h1, 0, 1'h1);
		run(TRG_EOF, FS_DATA, IDT_ANY, 1'h1, 1'h0, 1'h1, 0, 1'h1);
		run(TRG_FRAME, FS_DATA, IDT_BASE, 1'h0, 1'h0, 1'h1, 0, 1'h1);
		run(TRG_FRAME, FS_DATA, IDT_BASE, 1'h1, 1'h0, 1'h1, 0, 1'h0);
		run(TRG_FRAME, FS_REMOTE, IDT_EXT, 1'h1, 1'h1, 1'h1, 0, 1'h1);
		run(TRG_FRAME, FS_REMOTE, IDT_EXT, 1'h1, 1'h0, 1'h1, 0, 1'h0);
		run(TRG_FRAME, FS_DATA_REMOTE, IDT_ANY, 1'h0, 1'h1, 1'h1, 0, 1'h1);
		run(TRG_FRAME, FS_ERROR, IDT_ANY, 1'h0, 1'h0, 1'h1, 30, 1'h1);
		run(TRG_ID, FS_DATA, IDT_ANY, 1'h1, 1'h0, 1'h1, 0, 1'h1);
		run(TRG_ID, FS_DATA, IDT_ANY, 1'h0, 1'h0, 1'h1, 0, 1'h0);
		cfg.idCmp = CMP_RANGE;
		run(TRG_ID, FS_DATA, IDT_ANY, 1'h1, 1'h0, 1'h1, 0, 1'h1);
		cfg.idCmp = CMP_EQ;
		run(TRG_ID_DATA, FS_DATA, IDT_ANY, 1'h0, 1'h0, 1'h1, 0, 1'h1);
		cfg.errEnable = 4'h2;
		run(TRG_ERROR, FS_DATA, IDT_ANY, 1'h0, 1'h0, 1'h0, 0, 1'h1);
		cfg.errEnable = 4'h8;
		run(TRG_ERROR, FS_DATA, IDT_ANY, 1'h0, 1'h0, 1'h1, 30, 1'h1);
		end_of_test();
	end
	initial begin
		repeat (100000) @(posedge ref_clk);
		num_errors++;
		end_of_test();
	end
endmodule
bind can_frame_trigger_monitor can_trig_props chk_u (.ref_clk(ref_clk), .rst(rst), .busLine(busLine), .cfg(cfg),
	.status(status));
